// *** logic/pwst_pkg.sv ***
package pwst_pkg;

  localparam int unsigned NUM_CH = 4;
  localparam int unsigned CNT_W = 16;

  // reset values
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'hffff;
  localparam logic [CNT_W-1:0] CMP_RST = 16'h0000;
  localparam logic [CNT_W-1:0] COUNT_RST = 16'h0000;
  localparam logic [NUM_CH-1:0] RUN_RST = 4'h0;
  localparam logic [NUM_CH-1:0] SS_LOW_RST = 4'hf;

  // shared bit-per-channel fields sit in the low bits of the write data
  localparam int unsigned CH_FIELD_LSB = 0;

  // input synchroniser depth
  localparam int unsigned SYNC_STAGES = 3;

  typedef enum logic [2:0] {
    PWST_SHARED_START_REG = 3'h0,
    PWST_SHARED_STOP_REG = 3'h1,
    PWST_SHARED_CLEAR_REG = 3'h2,
    PWST_CHANNEL_COUNTER = 3'h3,
    PWST_CYCLE_PERIOD_REG = 3'h4,
    PWST_DUTY_COMPARE_A = 3'h5,
    PWST_DUTY_COMPARE_B = 3'h6,
    PWST_NONE = 3'h7
  } pwst_reg_e;

  typedef struct packed {
    logic valid;
    pwst_reg_e sel;
    logic [1:0] chan;
    logic [CNT_W-1:0] data;
  } pwst_wr_s;

  typedef struct packed {
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] cmp_a;
    logic [CNT_W-1:0] cmp_b;
  } pwst_cfg_s;

  typedef struct packed {
    logic [NUM_CH-1:0] pwm_out_a;
    logic [NUM_CH-1:0] pwm_out_b;
  } pwst_pins_s;

  typedef logic [NUM_CH-1:0][CNT_W-1:0] pwst_counts_t;

endpackage

// *** logic/pwst_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

module pwst_sync #(
  parameter int unsigned WIDTH = 4
) (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_level
);

  logic [WIDTH-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [WIDTH-1:0] lvl_d;

  // change accepted only once the last two stages agree
  always_comb begin
    lvl_d = lvl_q;
    for (int i = 0; i < int'(WIDTH); i++) begin
      if (s2_q[i] == s3_q[i]) begin
        lvl_d[i] = s3_q[i];
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      lvl_q <= '0;
    end else if (i_ce) begin
      s1_q <= i_async;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign o_level = lvl_q;

endmodule

`default_nettype wire

// *** logic/pwst_channel.sv ***
`timescale 1ns/1ps
`default_nettype none

module pwst_channel (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire logic i_run,
  input wire logic i_start_evt,
  input wire logic i_stop_evt,
  input wire logic i_clear,
  input wire logic i_load,
  input wire logic [pwst_pkg::CNT_W-1:0] i_load_val,
  input wire pwst_pkg::pwst_cfg_s i_cfg,
  input wire logic i_ss_low,
  output logic [pwst_pkg::CNT_W-1:0] o_count,
  output logic o_pwm_a,
  output logic o_pwm_b
);

  logic [pwst_pkg::CNT_W-1:0] cnt_q, cnt_d;
  logic pwm_a_q, pwm_a_d, pwm_b_q, pwm_b_d;
  logic cycle_end;

  assign cycle_end = i_run && (cnt_q == i_cfg.period);

  ////////////////////////////////////////////////////////////////////////
  // up-counter, wraps at the period value
  always_comb begin
    cnt_d = cnt_q;
    if (i_clear) begin
      cnt_d = pwst_pkg::COUNT_RST;
    end else if (i_load) begin
      cnt_d = i_load_val;
    end else if (cycle_end) begin
      cnt_d = pwst_pkg::COUNT_RST;
    end else if (i_run) begin
      cnt_d = cnt_q + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // output pins: low at start/stop when i_ss_low is set, high on match, low at cycle end
  always_comb begin
    pwm_a_d = pwm_a_q;
    pwm_b_d = pwm_b_q;
    if ((i_start_evt || i_stop_evt) && i_ss_low) begin
      pwm_a_d = 1'b0;
      pwm_b_d = 1'b0;
    end else if (cycle_end) begin
      pwm_a_d = 1'b0;
      pwm_b_d = 1'b0;
    end else if (i_run) begin
      if (cnt_q == i_cfg.cmp_a) begin
        pwm_a_d = 1'b1;
      end
      if (cnt_q == i_cfg.cmp_b) begin
        pwm_b_d = 1'b1;
      end
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      cnt_q <= pwst_pkg::COUNT_RST;
      pwm_a_q <= 1'b0;
      pwm_b_q <= 1'b0;
    end else if (i_ce) begin
      cnt_q <= cnt_d;
      pwm_a_q <= pwm_a_d;
      pwm_b_q <= pwm_b_d;
    end
  end

  assign o_count = cnt_q;
  assign o_pwm_a = pwm_a_q;
  assign o_pwm_b = pwm_b_q;

endmodule

`default_nettype wire

// *** logic/pwst_top.sv ***
`timescale 1ns/1ps
`default_nettype none

module pwst_top (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire pwst_pkg::pwst_wr_s i_wr,
  input wire logic [pwst_pkg::NUM_CH-1:0] i_hw_start_pin,
  input wire logic [pwst_pkg::NUM_CH-1:0] i_hw_stop_pin,
  input wire logic [pwst_pkg::NUM_CH-1:0] i_hw_start_source_select,
  input wire logic [pwst_pkg::NUM_CH-1:0] i_hw_stop_source_select,
  input wire logic [pwst_pkg::NUM_CH-1:0] i_ss_out_low,
  output pwst_pkg::pwst_pins_s o_pins,
  output logic [pwst_pkg::NUM_CH-1:0] o_shared_start_reg,
  output pwst_pkg::pwst_counts_t o_channel_counter
);

  localparam int unsigned NCH = pwst_pkg::NUM_CH;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers

  // bit-per-channel mask of a shared register write; zero bits stay zero
  function automatic logic [NCH-1:0] shared_bits(input pwst_pkg::pwst_wr_s wr,
                                                 input pwst_pkg::pwst_reg_e sel);
    shared_bits = '0;
    if (wr.valid && (wr.sel == sel)) begin
      shared_bits = wr.data[pwst_pkg::CH_FIELD_LSB +: NCH];
    end
  endfunction

  // per-channel register write hit
  function automatic logic chan_hit(input pwst_pkg::pwst_wr_s wr,
                                    input pwst_pkg::pwst_reg_e sel,
                                    input int unsigned idx);
    chan_hit = wr.valid && (wr.sel == sel) && (wr.chan == idx[1:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // hardware sources: pins, synchronised and edge-detected

  logic [NCH-1:0] hw_start_lvl, hw_stop_lvl;
  logic [NCH-1:0] hw_start_prev_q, hw_start_prev_d;
  logic [NCH-1:0] hw_stop_prev_q, hw_stop_prev_d;
  logic [NCH-1:0] hw_start_evt, hw_stop_evt;

  pwst_sync #(
    .WIDTH(NCH)
  ) u_sync_start (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_async(i_hw_start_pin),
    .o_level(hw_start_lvl)
  );

  pwst_sync #(
    .WIDTH(NCH)
  ) u_sync_stop (
    .i_mclk(i_mclk),
    .i_srst(i_srst),
    .i_ce(i_ce),
    .i_async(i_hw_stop_pin),
    .o_level(hw_stop_lvl)
  );

  always_comb begin
    hw_start_prev_d = hw_start_lvl;
    hw_stop_prev_d = hw_stop_lvl;
    hw_start_evt = hw_start_lvl & ~hw_start_prev_q & i_hw_start_source_select;
    hw_stop_evt = hw_stop_lvl & ~hw_stop_prev_q & i_hw_stop_source_select;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      hw_start_prev_q <= '0;
      hw_stop_prev_q <= '0;
    end else if (i_ce) begin
      hw_start_prev_q <= hw_start_prev_d;
      hw_stop_prev_q <= hw_stop_prev_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // shared start / stop / clear and count state

  logic [NCH-1:0] sw_start, sw_stop, sw_clear;
  logic [NCH-1:0] run_q, run_d;
  logic [NCH-1:0] start_evt, stop_evt;

  // the channel field of the write is ignored for shared registers
  assign sw_start = shared_bits(i_wr, pwst_pkg::PWST_SHARED_START_REG);
  assign sw_stop = shared_bits(i_wr, pwst_pkg::PWST_SHARED_STOP_REG);
  assign sw_clear = shared_bits(i_wr, pwst_pkg::PWST_SHARED_CLEAR_REG);

  // whole vector resolved in one cycle so selected channels move together
  always_comb begin
    run_d = run_q;
    for (int i = 0; i < int'(NCH); i++) begin
      if (sw_stop[i]) begin
        run_d[i] = 1'b0;
      end else if (sw_start[i]) begin
        run_d[i] = 1'b1;
      end else if (hw_stop_evt[i]) begin
        run_d[i] = 1'b0;
      end else if (hw_start_evt[i]) begin
        run_d[i] = 1'b1;
      end
    end
    start_evt = run_d & ~run_q;
    stop_evt = run_q & ~run_d;
  end

  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      run_q <= pwst_pkg::RUN_RST;
    end else if (i_ce) begin
      run_q <= run_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // per-channel configuration and counters

  pwst_pkg::pwst_cfg_s cfg_q [NCH];
  pwst_pkg::pwst_cfg_s cfg_d [NCH];
  logic [NCH-1:0] load;
  logic [NCH-1:0] pwm_a, pwm_b;
  pwst_pkg::pwst_counts_t counts;

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      always_comb begin
        cfg_d[g] = cfg_q[g];
        if (chan_hit(i_wr, pwst_pkg::PWST_CYCLE_PERIOD_REG, g)) begin
          cfg_d[g].period = i_wr.data;
        end
        if (chan_hit(i_wr, pwst_pkg::PWST_DUTY_COMPARE_A, g)) begin
          cfg_d[g].cmp_a = i_wr.data;
        end
        if (chan_hit(i_wr, pwst_pkg::PWST_DUTY_COMPARE_B, g)) begin
          cfg_d[g].cmp_b = i_wr.data;
        end
      end

      always_ff @(posedge i_mclk) begin
        if (i_srst) begin
          cfg_q[g].period <= pwst_pkg::PERIOD_RST;
          cfg_q[g].cmp_a <= pwst_pkg::CMP_RST;
          cfg_q[g].cmp_b <= pwst_pkg::CMP_RST;
        end else if (i_ce) begin
          cfg_q[g] <= cfg_d[g];
        end
      end

      // a running counter ignores direct writes, so a preload cannot tear a cycle
      assign load[g] = chan_hit(i_wr, pwst_pkg::PWST_CHANNEL_COUNTER, g) && !run_q[g];

      pwst_channel u_ch (
        .i_mclk(i_mclk),
        .i_srst(i_srst),
        .i_ce(i_ce),
        .i_run(run_q[g]),
        .i_start_evt(start_evt[g]),
        .i_stop_evt(stop_evt[g]),
        .i_clear(sw_clear[g]),
        .i_load(load[g]),
        .i_load_val(i_wr.data),
        .i_cfg(cfg_q[g]),
        .i_ss_low(i_ss_out_low[g]),
        .o_count(counts[g]),
        .o_pwm_a(pwm_a[g]),
        .o_pwm_b(pwm_b[g])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // outputs: all straight from flops

  assign o_pins.pwm_out_a = pwm_a;
  assign o_pins.pwm_out_b = pwm_b;
  assign o_shared_start_reg = run_q;
  assign o_channel_counter = counts;

endmodule

`default_nettype wire

// *** verif/pwst_top_assertions.sv ***
`timescale 1ns/1ps
`default_nettype none
module pwst_top_assertions (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_ce,
  input wire pwst_pkg::pwst_wr_s i_wr,
  input wire logic [pwst_pkg::NUM_CH-1:0] i_hw_start_source_select,
  input wire logic [pwst_pkg::NUM_CH-1:0] i_hw_stop_source_select,
  input wire logic [pwst_pkg::NUM_CH-1:0] i_ss_out_low,
  input wire pwst_pkg::pwst_pins_s o_pins,
  input wire logic [pwst_pkg::NUM_CH-1:0] o_shared_start_reg,
  input wire pwst_pkg::pwst_counts_t o_channel_counter
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  logic wv;
  logic quiet;
  logic st;
  logic sp;
  logic cl;
  logic ld;
  logic [3:0] m;
  // hw sources off, so only processor writes move the run state
  assign quiet = i_ce && !(|i_hw_start_source_select) && !(|i_hw_stop_source_select);
  assign wv = i_wr.valid && i_ce;
  assign st = i_wr.sel == pwst_pkg::PWST_SHARED_START_REG;
  assign sp = i_wr.sel == pwst_pkg::PWST_SHARED_STOP_REG;
  assign cl = i_wr.sel == pwst_pkg::PWST_SHARED_CLEAR_REG;
  assign ld = i_wr.sel == pwst_pkg::PWST_CHANNEL_COUNTER;
  assign m = i_wr.data[3:0];
  //////////
  AST_START: assert property (wv && st |=> (o_shared_start_reg & $past(m)) == $past(m))
    else $error("start bits not running");
  AST_STOP: assert property (wv && sp |=> (o_shared_start_reg & $past(m)) == 4'h0)
    else $error("stop bits still running");
  AST_ZERO: assert property (wv && (st || sp || cl) && quiet |=>
    (o_shared_start_reg & ~$past(m)) == ($past(o_shared_start_reg) & ~$past(m))) else $error("zero bit moved");
  for (genvar c = 0; c < 4; c++) begin : g_ch
    AST_CLEAR: assert property (wv && cl && m[c] |=> o_channel_counter[c] == 16'h0000)
      else $error("counter not cleared");
    AST_COUNT: assert property (o_shared_start_reg[c] && !wv && quiet |=>
      o_channel_counter[c] == $past(o_channel_counter[c]) + 16'h0001 || o_channel_counter[c] == 16'h0000)
      else $error("counter not counting up");
    AST_HOLD: assert property (!o_shared_start_reg[c] && !wv && quiet |=> $stable(o_channel_counter[c]))
      else $error("stopped counter moved");
    AST_LOAD: assert property (wv && ld && i_wr.chan == c && !o_shared_start_reg[c] |=>
      o_channel_counter[c] == $past(i_wr.data)) else $error("counter load lost");
    // only a real start or stop forces the pins; a repeated write leaves them alone
    AST_PIN: assert property (wv && m[c] && i_ss_out_low[c] &&
      ((st && !o_shared_start_reg[c]) || (sp && o_shared_start_reg[c])) |-> ##1
      !o_pins.pwm_out_a[c] && !o_pins.pwm_out_b[c]) else $error("pin not low at start or stop");
  end
  cover property (wv && st && m == 4'hf);
  cover property (wv && sp ##1 wv && cl);
  cover property (o_pins.pwm_out_a[0] && o_pins.pwm_out_b[0]);
endmodule
bind pwst_top pwst_top_assertions i_chk (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_wr(i_wr),
  .i_hw_start_source_select(i_hw_start_source_select), .i_hw_stop_source_select(i_hw_stop_source_select),
  .i_ss_out_low(i_ss_out_low), .o_pins(o_pins), .o_shared_start_reg(o_shared_start_reg),
  .o_channel_counter(o_channel_counter));
`default_nettype wire

// *** verif/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic i_mclk = 1'b0;
  logic i_srst = 1'b1;
  logic i_ce = 1'b1;
  pwst_pkg::pwst_wr_s i_wr = '0;
  logic [3:0] start_pin = 4'h0;
  logic [3:0] stop_pin = 4'h0;
  logic [3:0] start_sel = 4'h0;
  logic [3:0] stop_sel = 4'h0;
  logic [3:0] ss_low = 4'h0;
  pwst_pkg::pwst_pins_s pins;
  logic [3:0] run;
  pwst_pkg::pwst_counts_t cnt;
  int failures = 0;
  int comparisons = 0;
  always #5 i_mclk = ~i_mclk;
  pwst_top i_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_ce(i_ce), .i_wr(i_wr), .i_hw_start_pin(start_pin),
    .i_hw_stop_pin(stop_pin), .i_hw_start_source_select(start_sel), .i_hw_stop_source_select(stop_sel),
    .i_ss_out_low(ss_low), .o_pins(pins), .o_shared_start_reg(run), .o_channel_counter(cnt));
  //////////
  task automatic chk(input string nm, input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic finish_test();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      #1;
    end
  endtask
  // leaves valid high so writes can run back to back; idle drops it
  task automatic wr(input pwst_pkg::pwst_reg_e sel, input logic [1:0] ch, input logic [15:0] d);
    i_wr = '{1'b1, sel, ch, d};
    cyc(1);
  endtask
  task automatic idle();
    i_wr.valid = 1'b0;
    cyc(1);
  endtask
  task automatic go(input logic [3:0] m);
    wr(pwst_pkg::PWST_SHARED_START_REG, 2'h1, {12'h000, m});
  endtask
  task automatic halt(input logic [3:0] m);
    wr(pwst_pkg::PWST_SHARED_STOP_REG, 2'h2, {12'h000, m});
  endtask
  task automatic clr(input logic [3:0] m);
    wr(pwst_pkg::PWST_SHARED_CLEAR_REG, 2'h3, {12'h000, m});
  endtask
  task automatic cfg(input logic [1:0] ch, input logic [15:0] p, input logic [15:0] a, input logic [15:0] b);
    wr(pwst_pkg::PWST_CYCLE_PERIOD_REG, ch, p);
    wr(pwst_pkg::PWST_DUTY_COMPARE_A, ch, a);
    wr(pwst_pkg::PWST_DUTY_COMPARE_B, ch, b);
  endtask
  //////////
  task automatic s_pins();
    ss_low = 4'hf;
    cfg(2'h0, 16'h0009, 16'h0003, 16'h0006);
    go(4'h1);
    idle();
    for (int k = 1; k < 16; k++) begin
      chk("pin_a", pins.pwm_out_a[0], k % 10 >= 4);
      chk("pin_b", pins.pwm_out_b[0], k % 10 >= 7);
      chk("cnt0", cnt[0], k % 10);
      cyc(1);
    end
    halt(4'h1);
    chk("stop_a", pins.pwm_out_a[0], 1'b0);
    idle();
  endtask
  task automatic s_phase();
    logic [15:0] pre [4] = '{16'h257f, 16'h18ff, 16'h0c7f, 16'h0000};
    for (int c = 0; c < 4; c++) begin
      cfg(2'(c), 16'h2580, 16'h1000, 16'h2000);
      wr(pwst_pkg::PWST_CHANNEL_COUNTER, 2'(c), pre[c]);
    end
    go(4'hf);
    idle();
    cyc(2);
    for (int c = 0; c < 4; c++) begin
      chk("run", run[c], 1'b1);
      chk("phase", cnt[c], 16'((int'(pre[c]) + 3) % 9601));
    end
  endtask
  task automatic s_stopclr();
    halt(4'hf);
    clr(4'hf);
    idle();
    chk("stopped", run, 4'h0);
    for (int c = 0; c < 4; c++) chk("cleared", cnt[c], 16'h0000);
    go(4'hf);
    idle();
    cyc(4);
    for (int c = 0; c < 4; c++) chk("aligned", cnt[c], 16'h0005);
  endtask
  task automatic s_zero();
    go(4'h5);
    go(4'h0);
    halt(4'h1);
    halt(4'h0);
    clr(4'h4);
    idle();
    chk("run", run, 4'he);
    chk("clr2", cnt[2], 16'h0001);
    chk("keep3", cnt[3], 16'h000b);
    chk("hold0", cnt[0], 16'h0008);
  endtask
  // writes while the clock enable is low must not land
  task automatic s_freeze();
    logic [15:0] held;
    held = cnt[1];
    i_ce = 1'b0;
    halt(4'hf);
    clr(4'hf);
    idle();
    chk("frz_run", run, 4'hf);
    chk("frz_cnt", cnt[1], held);
    i_ce = 1'b1;
    cyc(1);
    chk("thaw_cnt", cnt[1], 16'(held + 16'h0001));
  endtask
  task automatic s_hw();
    start_sel = 4'h1;
    stop_sel = 4'h4;
    start_pin = 4'h1;
    stop_pin = 4'h4;
    for (int k = 0; k < 12; k++) begin
      go(4'h4);
      chk("cpu_wins", run[2], 1'b1);
    end
    idle();
    chk("hw_start", run[0], 1'b1);
    start_sel = 4'h0;
    stop_sel = 4'h0;
  endtask
  initial begin
    cyc(16);
    i_srst = 1'b0;
    cyc(1);
    chk("rst_run", run, 4'h0);
    chk("rst_pins", pins, 8'h00);
    s_pins();
    s_phase();
    s_stopclr();
    s_zero();
    s_hw();
    s_freeze();
    finish_test();
  end
  initial begin
    cyc(5000);
    failures++;
    finish_test();
  end
endmodule
`default_nettype wire
